//--- src/codec_ctrl_pkg.sv
// constants shared by the codec control front end and its link receiver
// assumes: one core clock plus the host-driven link clock
//
// How it works
// - mode pins pick serial, static, test or spare
// - static: pin 3 picks 256fs or 384fs
// - static: pin 2 low/mid/high: none, 44.1k, mute
// - static: pins 1 and 5 pick data format
// - static: pin 4 low/mid/high: ADC off, 6dB, 0dB
// - serial: pins are flag, link lines, gain
// - serial: flag samples above -1.16 dB full scale
// - flag held 512 samples, restarted per hit
// - serial: pin 5 low 0dB, high 6dB
// - link bits arrive least significant first
// - address bits 7..2 compared with own address
// - address bits 1..0 pick data or status
// - foreign address deselects, following bytes ignored
// - selection holds until next address byte
// - link data line is input only
// - byte stored only after eighth bit
// - top two bits pick register, six load
// - status byte: ratio, format, dc filter enable
package codec_ctrl_pkg;

  typedef enum logic [3:0] {
    MODE_SERIAL = 4'h1,
    MODE_TEST   = 4'h2,
    MODE_SPARE  = 4'h4,
    MODE_STATIC = 4'h8
  } mode_t;

  localparam logic [1:0] XFER_DATA   = 2'h0;
  localparam logic [1:0] XFER_STATUS = 2'h2;

  localparam logic [1:0] CLK_512 = 2'h0;
  localparam logic [1:0] CLK_384 = 2'h1;
  localparam logic [1:0] CLK_256 = 2'h2;

  localparam logic [2:0] FMT_I2S       = 3'h0;
  localparam logic [2:0] FMT_MSB       = 3'h4;
  localparam logic [2:0] FMT_LSB16_MSB = 3'h5;
  localparam logic [2:0] FMT_LSB20_MSB = 3'h7;

  localparam logic [1:0] DEEMPH_NONE = 2'h0;
  localparam logic [1:0] DEEMPH_44K1 = 2'h2;

  localparam logic [1:0] GRP_VOLUME = 2'h0;
  localparam logic [1:0] GRP_TONE   = 2'h1;
  localparam logic [1:0] GRP_MODE   = 2'h2;
  localparam logic [1:0] GRP_POWER  = 2'h3;

  // reset values of the link-loaded settings
  localparam logic [1:0] RST_CLOCK_RATIO = 2'h0;
  localparam logic [2:0] RST_FORMAT      = 3'h0;
  localparam logic [5:0] RST_GROUP       = 6'h00;

  // overload threshold as a fraction of 2^19 (-1.16 dB)
  localparam int unsigned OVL_FRAC_NUM     = 458890;
  localparam int unsigned OVL_FRAC_SHIFT   = 19;
  localparam int unsigned OVL_HOLD_SAMPLES = 512;
  localparam int unsigned SAMPLE_BITS      = 20;

endpackage : codec_ctrl_pkg

//--- src/link_byte_if.sv
// carries whole received link bytes out of the link clock domain
// assumes: rx_toggle flips once per byte, byte and kind stable meanwhile
interface link_byte_if;
  logic [7:0] rx_byte;
  logic [1:0] rx_kind;
  logic       rx_toggle;
  modport rx   (output rx_byte, output rx_kind, output rx_toggle);
  modport core (input rx_byte, input rx_kind, input rx_toggle);
endinterface : link_byte_if

//--- src/link_receiver.sv
// serial control link receiver, runs on the host's link clock
// assumes: link clock only toggles during transfers, rst is asynchronous
module link_receiver
  import codec_ctrl_pkg::*;
#(
  parameter logic [5:0] DEVICE_ADDRESS = 6'h2a // value is arbitrary
) (
  input  wire logic  link_clk,
  input  wire logic  rst,
  input  wire logic  link_phase_line,
  input  wire logic  link_data_line,
  link_byte_if.rx    lnk
);

  logic [7:0] shift_ff;
  logic [2:0] count_ff;
  logic       phase_ff;
  logic       select_ff;
  logic [1:0] kind_ff;

  ////////////////////////////////////////////////////////////////////////
  // a phase change restarts the bit count, so a stray clock cannot skew
  wire logic       restart   = link_phase_line != phase_ff;
  wire logic [2:0] bit_pos   = restart ? 3'h0 : count_ff;
  wire logic [2:0] nxt_count = bit_pos + 3'h1;
  wire logic [7:0] nxt_shift = {link_data_line, shift_ff[7:1]};
  wire logic       byte_done = bit_pos == 3'h7;
  wire logic       addr_done = byte_done && !link_phase_line;
  wire logic       addr_ok   = nxt_shift[7:2] == DEVICE_ADDRESS;
  wire logic       kind_ok   = kind_ff == XFER_DATA ||
                               kind_ff == XFER_STATUS;
  wire logic       data_done = byte_done && link_phase_line &&
                               select_ff && kind_ok;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      shift_ff <= 8'h00;
      count_ff <= 3'h0;
      phase_ff <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      count_ff <= nxt_count;
      phase_ff <= link_phase_line;
    end
  end

  // selection only changes on a full address byte
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      select_ff <= 1'b0;
      kind_ff   <= XFER_DATA;
    end else if (addr_done) begin
      select_ff <= addr_ok;
      kind_ff   <= nxt_shift[1:0];
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lnk.rx_byte   <= 8'h00;
      lnk.rx_kind   <= XFER_DATA;
      lnk.rx_toggle <= 1'b0;
    end else if (data_done) begin
      lnk.rx_byte   <= nxt_shift;
      lnk.rx_kind   <= kind_ff;
      lnk.rx_toggle <= ~lnk.rx_toggle;
    end
  end

endmodule : link_receiver

//--- src/codec_control_mode_interface.sv
// control front end: mode pins, static pin decode, serial link settings
// and the ADC overload flag
// assumes: pins asynchronous to ref_clk; ADC samples on ref_clk with a
// one-cycle strobe per sample period
module codec_control_mode_interface
  import codec_ctrl_pkg::*;
#(
  parameter int unsigned SAMPLE_W       = SAMPLE_BITS,
  parameter int unsigned OVL_HOLD       = OVL_HOLD_SAMPLES,
  parameter logic [5:0]  DEVICE_ADDRESS = 6'h2a // value is arbitrary
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                control_style_pin_a,
  input  wire logic                control_style_pin_b,
  input  wire logic                multi_purpose_pin_1_in,
  output logic                     multi_purpose_pin_1_out,
  output logic                     multi_purpose_pin_1_oe,
  input  wire logic [1:0]          multi_purpose_pin_2,
  input  wire logic                multi_purpose_pin_3,
  input  wire logic [1:0]          multi_purpose_pin_4,
  input  wire logic                multi_purpose_pin_5,
  input  wire logic                sample_strobe,
  input  wire logic [SAMPLE_W-1:0] adc_left_sample,
  input  wire logic [SAMPLE_W-1:0] adc_right_sample,
  output mode_t                    control_mode,
  output logic [1:0]               clock_ratio_field,
  output logic [2:0]               data_format,
  output logic                     dc_filter_enable,
  output logic [1:0]               deemphasis,
  output logic                     mute,
  output logic                     adc_gain_6db,
  output logic                     adc_power_down,
  output logic [5:0]               volume,
  output logic [3:0]               bass_boost,
  output logic [1:0]               treble,
  output logic [1:0]               filter_mode,
  output logic [1:0]               power_control
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks

  localparam int unsigned CNT_W = $clog2(OVL_HOLD + 1);

  if (SAMPLE_W < 8 || SAMPLE_W > 32) begin : g_bad_width
    $error("sample width must be 8 to 32");
  end
  if (OVL_HOLD < 2 || OVL_HOLD > 65535) begin : g_bad_hold
    $error("overload hold must be 2 to 65535 samples");
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, a change counts when two agree

  localparam int unsigned NPIN     = 9;
  localparam int unsigned P_STYLE_A = 0;
  localparam int unsigned P_STYLE_B = 1;
  localparam int unsigned P_MP1     = 2;
  localparam int unsigned P_MP2_MID = 3;
  localparam int unsigned P_MP2_HI  = 4;
  localparam int unsigned P_MP3     = 5;
  localparam int unsigned P_MP4_MID = 6;
  localparam int unsigned P_MP4_HI  = 7;
  localparam int unsigned P_MP5     = 8;

  wire logic [NPIN-1:0] pin_raw = {
    multi_purpose_pin_5,
    multi_purpose_pin_4[1],
    multi_purpose_pin_4[0],
    multi_purpose_pin_3,
    multi_purpose_pin_2[1],
    multi_purpose_pin_2[0],
    multi_purpose_pin_1_in,
    control_style_pin_b,
    control_style_pin_a
  };

  logic [NPIN-1:0] pin_s1_ff;
  logic [NPIN-1:0] pin_s2_ff;
  logic [NPIN-1:0] pin_s3_ff;
  logic [NPIN-1:0] pin_ff;

  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        pin_s1_ff[i] <= 1'b0;
        pin_s2_ff[i] <= 1'b0;
        pin_s3_ff[i] <= 1'b0;
        pin_ff[i]    <= 1'b0;
      end else begin
        pin_s1_ff[i] <= pin_raw[i];
        pin_s2_ff[i] <= pin_s1_ff[i];
        pin_s3_ff[i] <= pin_s2_ff[i];
        if (pin_s2_ff[i] == pin_s3_ff[i]) begin
          pin_ff[i] <= pin_s3_ff[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode decode

  mode_t mode_ff;

  wire logic  style_a = pin_ff[P_STYLE_A];
  wire logic  style_b = pin_ff[P_STYLE_B];
  wire mode_t nxt_mode =
    (!style_a && !style_b) ? MODE_SERIAL :
    ( style_a &&  style_b) ? MODE_STATIC :
    ( style_a && !style_b) ? MODE_TEST   : MODE_SPARE;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= MODE_SERIAL;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  wire logic in_serial = mode_ff == MODE_SERIAL;
  wire logic in_static = mode_ff == MODE_STATIC;

  // three-level pins arrive as a low/mid/high comparator pair
  wire logic mp2_high = pin_ff[P_MP2_HI];
  wire logic mp2_mid  = pin_ff[P_MP2_MID] && !pin_ff[P_MP2_HI];
  wire logic mp4_high = pin_ff[P_MP4_HI];
  wire logic mp4_mid  = pin_ff[P_MP4_MID] && !mp4_high;
  wire logic mp4_low  = !pin_ff[P_MP4_MID] && !pin_ff[P_MP4_HI];

  ////////////////////////////////////////////////////////////////////////
  // serial link: pin 2 phase, pin 3 clock, pin 4 data, never driven

  link_byte_if lnk ();

  link_receiver #(
    .DEVICE_ADDRESS (DEVICE_ADDRESS)
  ) u_link_receiver (
    .link_clk        (multi_purpose_pin_3),
    .rst             (rst),
    .link_phase_line (multi_purpose_pin_2[1]),
    .link_data_line  (multi_purpose_pin_4[1]),
    .lnk             (lnk.rx)
  );

  // byte toggle crossing; byte and kind are stable long before it
  // settles since the host rate is bounded well below ref_clk
  logic tgl_s1_ff;
  logic tgl_s2_ff;
  logic tgl_s3_ff;
  logic tgl_seen_ff;

  wire logic tgl_agree = tgl_s2_ff == tgl_s3_ff;
  wire logic byte_evt  = tgl_agree && (tgl_s3_ff != tgl_seen_ff);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tgl_s1_ff   <= 1'b0;
      tgl_s2_ff   <= 1'b0;
      tgl_s3_ff   <= 1'b0;
      tgl_seen_ff <= 1'b0;
    end else begin
      tgl_s1_ff <= lnk.rx_toggle;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
      if (tgl_agree) begin
        tgl_seen_ff <= tgl_s3_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link-loaded settings

  logic [1:0] sc_ff;
  logic [2:0] fmt_ff;
  logic       dc_ff;
  logic [5:0] group_ff [4];

  wire logic [7:0] rx_byte   = lnk.rx_byte;
  wire logic [1:0] rx_group  = rx_byte[7:6];
  wire logic       take_byte = byte_evt && in_serial;
  wire logic       take_stat = take_byte && lnk.rx_kind == XFER_STATUS &&
                               rx_group == 2'h0;
  wire logic       take_data = take_byte && lnk.rx_kind == XFER_DATA;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sc_ff  <= RST_CLOCK_RATIO;
      fmt_ff <= RST_FORMAT;
      dc_ff  <= 1'b0;
    end else if (take_stat) begin
      sc_ff  <= rx_byte[5:4];
      fmt_ff <= rx_byte[3:1];
      dc_ff  <= rx_byte[0];
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_group
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        group_ff[g] <= RST_GROUP;
      end else if (take_data && rx_group == 2'(g)) begin
        group_ff[g] <= rx_byte[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // overload detector

  localparam logic [SAMPLE_W-1:0] OVL_THR = SAMPLE_W'(
    (64'(OVL_FRAC_NUM) << (SAMPLE_W - 1)) >> OVL_FRAC_SHIFT);

  // negating the most negative code wraps to itself, still above limit
  wire logic [SAMPLE_W-1:0] mag_left  = adc_left_sample[SAMPLE_W-1] ?
    SAMPLE_W'(-adc_left_sample) : adc_left_sample;
  wire logic [SAMPLE_W-1:0] mag_right = adc_right_sample[SAMPLE_W-1] ?
    SAMPLE_W'(-adc_right_sample) : adc_right_sample;
  wire logic over_level = mag_left > OVL_THR ||
                          mag_right > OVL_THR;
  wire logic ovl_hit    = sample_strobe && in_serial && over_level;

  logic [CNT_W-1:0] ovl_cnt_ff;

  wire logic [CNT_W-1:0] nxt_ovl_cnt =
    ovl_hit ? CNT_W'(OVL_HOLD) :
    (sample_strobe && ovl_cnt_ff != '0) ? ovl_cnt_ff - CNT_W'(1) :
    ovl_cnt_ff;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovl_cnt_ff <= '0;
    end else begin
      ovl_cnt_ff <= nxt_ovl_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output selection

  wire logic [1:0] nxt_ratio = in_static ?
    (pin_ff[P_MP3] ? CLK_384 : CLK_256) : sc_ff;

  wire logic [1:0] fmt_pins = {pin_ff[P_MP1], pin_ff[P_MP5]};
  wire logic [2:0] static_fmt =
    (fmt_pins == 2'h0) ? FMT_MSB :
    (fmt_pins == 2'h1) ? FMT_I2S :
    (fmt_pins == 2'h2) ? FMT_LSB20_MSB : FMT_LSB16_MSB;
  wire logic [2:0] nxt_format = in_static ? static_fmt : fmt_ff;

  wire logic [5:0] mode_grp = group_ff[GRP_MODE];
  wire logic [1:0] nxt_deemph = in_static ?
    (mp2_mid ? DEEMPH_44K1 : DEEMPH_NONE) : mode_grp[4:3];
  wire logic nxt_mute = in_static ? mp2_high : mode_grp[2];

  // pin 4 carries link data in serial, so it must not reach the gain
  wire logic nxt_gain = in_static ? mp4_mid :
                        pin_ff[P_MP5];
  wire logic nxt_pdown = in_static && mp4_low;

  wire logic nxt_ovl_out = in_serial &&
                           (ovl_hit || nxt_ovl_cnt != '0);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      control_mode            <= MODE_SERIAL;
      clock_ratio_field       <= RST_CLOCK_RATIO;
      data_format             <= RST_FORMAT;
      dc_filter_enable        <= 1'b0;
      deemphasis              <= DEEMPH_NONE;
      mute                    <= 1'b0;
      adc_gain_6db            <= 1'b0;
      adc_power_down          <= 1'b0;
      multi_purpose_pin_1_out <= 1'b0;
      multi_purpose_pin_1_oe  <= 1'b0;
    end else begin
      control_mode            <= mode_ff;
      clock_ratio_field       <= nxt_ratio;
      data_format             <= nxt_format;
      dc_filter_enable        <= !in_static && dc_ff;
      deemphasis              <= nxt_deemph;
      mute                    <= nxt_mute;
      adc_gain_6db            <= nxt_gain;
      adc_power_down          <= nxt_pdown;
      multi_purpose_pin_1_out <= nxt_ovl_out;
      multi_purpose_pin_1_oe  <= in_serial;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      volume        <= RST_GROUP;
      bass_boost    <= 4'h0;
      treble        <= 2'h0;
      filter_mode   <= 2'h0;
      power_control <= 2'h0;
    end else begin
      volume        <= group_ff[GRP_VOLUME];
      bass_boost    <= group_ff[GRP_TONE][5:2];
      treble        <= group_ff[GRP_TONE][1:0];
      filter_mode   <= mode_grp[1:0];
      power_control <= group_ff[GRP_POWER][1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_mode_static: assert property (
    style_a && style_b |=> mode_ff == MODE_STATIC)
    else $error("both mode pins high did not give static mode");

  chk_static_ratio: assert property (
    in_static && pin_ff[P_MP3] |=> clock_ratio_field == CLK_384)
    else $error("static pin 3 high did not select 384fs");

  chk_static_mute: assert property (
    in_static |=> mute == $past(mp2_high) &&
      (deemphasis == DEEMPH_44K1) == $past(mp2_mid))
    else $error("static pin 2 decode wrong");

  chk_static_format: assert property (
    in_static && fmt_pins == 2'h1 |=> data_format == FMT_I2S)
    else $error("static format pins low/high not I2S");

  chk_static_power: assert property (
    in_static && mp4_low |=> adc_power_down && !adc_gain_6db)
    else $error("static pin 4 low did not power down");

  chk_flag_pin_role: assert property (
    in_serial ##1 in_serial |=> multi_purpose_pin_1_oe)
    else $error("flag pin not driven in serial mode");

  chk_ovl_raise: assert property (
    ovl_hit |=> multi_purpose_pin_1_out &&
      ovl_cnt_ff == CNT_W'(OVL_HOLD))
    else $error("overload did not raise and restart flag");

  chk_ovl_hold: assert property (
    in_serial && ovl_cnt_ff > CNT_W'(1) |=> multi_purpose_pin_1_out)
    else $error("overload flag dropped before hold ended");

  chk_serial_gain: assert property (
    in_serial |=> adc_gain_6db == $past(pin_ff[P_MP5]))
    else $error("serial gain does not follow pin 5");

  chk_status_load: assert property (
    take_stat |-> ##2 dc_filter_enable == $past(rx_byte[0], 2) &&
      data_format == $past(rx_byte[3:1], 2))
    else $error("status byte not loaded");

endmodule : codec_control_mode_interface

//--- tb/link_host_model.sv
// host side of the three-wire control link, behavioural
// assumes: caller runs send_byte to completion; clock idles low
module link_host_model (
  output logic link_clk,
  output logic link_phase,
  output logic link_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // 80 ns period, well under the 64fs ceiling
  localparam time HALF = 40ns;
  // start off the core clock edges so the two clocks never coincide
  localparam time SKEW = 3ns;

  initial begin
    link_clk   = 1'b0;
    link_phase = 1'b0;
    link_data  = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic send_byte(input logic phase, input logic [7:0] b);
    #SKEW;
    link_phase = phase; // low for address, high for data
    #HALF;
    for (int i = 0; i < 8; i++) begin // lsb first, 8 pulses
      link_data = b[i]; // only moved while clock low
      #HALF;
      link_clk = 1'b1;
      #HALF;
      link_clk = 1'b0;
    end
    #HALF;
    // released: show the inverse so a stale level cannot pass
    link_data = ~b[7];
  endtask : send_byte
endmodule : link_host_model

//--- tb/codec_control_mode_interface_tb.sv
// self-checking bench for the codec control front end
// assumes: host model drives pins 2..4 whenever both mode pins are low
module codec_control_mode_interface_tb
  import codec_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [5:0] ADDR = 6'h2a; // value is arbitrary
  localparam int HOLD = 4; // short hold keeps the run brief
  localparam int THR  = OVL_FRAC_NUM << (SAMPLE_BITS - 1 - OVL_FRAC_SHIFT);

  logic                   ref_clk, rst, pin_a, pin_b, p1_r, p3_r, p5;
  logic                   strobe;
  logic [1:0]             p2_r, p4_r;
  logic [SAMPLE_BITS-1:0] left, right;
  wire                    lk, lph, ldat, p1, p3;
  wire  [1:0]             p2, p4;
  wire                    ser = !pin_a && !pin_b;
  logic                   p1_out, p1_oe, dc, mute, gain, pdn;
  mode_t                  control_mode;
  logic [1:0]             ratio, deem, treble, fmode, pwr;
  logic [2:0]             fmt;
  logic [5:0]             volume;
  logic [3:0]             bass;
  int error_cnt, samples_checked, ovl_cnt, sel, kind;
  int e_vol, e_bass, e_treb, e_fm, e_pwr, e_deem, e_mute, e_rat, e_fmt, e_dc;
  logic [8:0] seq[$];
  logic [31:0] r;

  // pin 1 wire level from both drivers
  assign p1 = p1_oe ? p1_out : p1_r;
  assign p2 = ser ? {lph, 1'b0} : p2_r;
  assign p3 = ser ? lk : p3_r;
  assign p4 = ser ? {ldat, 1'b0} : p4_r;

  link_host_model u_link_host_model (.link_clk(lk), .link_phase(lph),
    .link_data(ldat));

  codec_control_mode_interface #(.OVL_HOLD(HOLD), .DEVICE_ADDRESS(ADDR))
  u_codec_control_mode_interface (.ref_clk(ref_clk), .rst(rst),
    .control_style_pin_a(pin_a), .control_style_pin_b(pin_b),
    .multi_purpose_pin_1_in(p1), .multi_purpose_pin_1_out(p1_out),
    .multi_purpose_pin_1_oe(p1_oe), .multi_purpose_pin_2(p2),
    .multi_purpose_pin_3(p3), .multi_purpose_pin_4(p4),
    .multi_purpose_pin_5(p5), .sample_strobe(strobe),
    .adc_left_sample(left), .adc_right_sample(right),
    .control_mode(control_mode), .clock_ratio_field(ratio),
    .data_format(fmt), .dc_filter_enable(dc), .deemphasis(deem),
    .mute(mute), .adc_gain_6db(gain), .adc_power_down(pdn),
    .volume(volume), .bass_boost(bass), .treble(treble),
    .filter_mode(fmode), .power_control(pwr));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic cmp_set;
    chk(volume, e_vol);
    chk(bass, e_bass);
    chk(treble, e_treb);
    chk(deem, e_deem);
    chk(mute, e_mute);
    chk(fmode, e_fm);
    chk(pwr, e_pwr);
    chk(ratio, e_rat);
    chk(fmt, e_fmt);
    chk(dc, e_dc);
  endtask : cmp_set

  // reference: address picks selection and kind, data bytes load groups
  task automatic lbyte(input logic [8:0] v);
    u_link_host_model.send_byte(v[8], v[7:0]);
    if (!v[8]) begin
      sel  = (v[7:2] == ADDR);
      kind = v[1:0];
    end else if (sel && kind == XFER_DATA) begin
      if (v[7:6] == GRP_VOLUME) e_vol = v[5:0];
      if (v[7:6] == GRP_TONE) begin
        e_bass = v[5:2];
        e_treb = v[1:0];
      end
      if (v[7:6] == GRP_MODE) begin
        e_deem = v[4:3];
        e_mute = v[2];
        e_fm   = v[1:0];
      end
      if (v[7:6] == GRP_POWER) e_pwr = v[1:0];
    end else if (sel && kind == XFER_STATUS && v[7:6] == 2'h0) begin
      e_rat = v[5:4];
      e_fmt = v[3:1];
      e_dc  = v[0];
    end
    cyc(30);
    cmp_set();
  endtask : lbyte

  task automatic smp(input int lv, input int rv);
    @(posedge ref_clk);
    strobe <= 1'b1;
    left   <= lv[SAMPLE_BITS-1:0];
    right  <= rv[SAMPLE_BITS-1:0];
    @(posedge ref_clk);
    strobe <= 1'b0;
    if ((lv < 0 ? -lv : lv) > THR || (rv < 0 ? -rv : rv) > THR)
      ovl_cnt = HOLD;
    else if (ovl_cnt > 0)
      ovl_cnt--;
    cyc(3);
    chk(p1_out, ovl_cnt > 0);
  endtask : smp

  task automatic pins(input logic a, input logic b, input logic [31:0] v);
    @(posedge ref_clk);
    {pin_a, pin_b} <= {a, b};
    {p1_r, p2_r, p3_r, p4_r, p5} <= v[6:0];
    cyc(12);
  endtask : pins

  //////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(100000);
    error_cnt++;
    $display("[FAIL] %0t run limit reached", $time);
    results();
  end

  initial begin
    static mode_t mtab [4] = '{MODE_SERIAL, MODE_TEST, MODE_SPARE,
                               MODE_STATIC};
    static logic [2:0] ftab [4] = '{FMT_MSB, FMT_I2S, FMT_LSB20_MSB,
                                    FMT_LSB16_MSB};
    {rst, pin_a, pin_b, p1_r, p2_r, p3_r, p4_r, p5} = {1'b1, 9'h0};
    {strobe, left, right} = '0;
    {error_cnt, samples_checked, ovl_cnt, sel, kind} = '0;
    {e_vol, e_bass, e_treb, e_fm, e_pwr, e_deem, e_mute} = '0;
    {e_rat, e_fmt, e_dc} = '0;
    void'($urandom(66268));
    cyc(10);
    rst <= 1'b0;
    cyc(10);
    chk(control_mode, MODE_SERIAL);
    chk(p1_oe, 1'b1);
    cmp_set();
    pins(1'b0, 1'b0, 32'h1);
    chk(gain, 1'b1);
    pins(1'b0, 1'b0, 32'h0);
    chk(gain, 1'b0);
    $display("reset and gain test done");
    seq = '{{1'b0, ADDR, XFER_DATA}, 9'h12d, 9'h16e, 9'h197, 9'h1c2,
      {1'b0, ADDR, XFER_STATUS}, 9'h12f, 9'h17f,
      {1'b0, ADDR ^ 6'h01, XFER_DATA}, 9'h103, {1'b0, ADDR, 2'h1}, 9'h107,
      {1'b0, ADDR, 2'h3}, 9'h107, {1'b0, ADDR, XFER_DATA}, 9'h13f, 9'h101};
    foreach (seq[i]) lbyte(seq[i]);
    // link data was left high: gain must still follow pin 5 alone
    pins(1'b0, 1'b0, 32'h1);
    chk(gain, 1'b1);
    $display("link test done");
    smp(THR + 1, 0);
    for (int i = 0; i < HOLD - 1; i++) smp(THR - 1, 0);
    smp(0, -(THR + 1));
    for (int i = 0; i < HOLD; i++) smp(0, 1 - THR);
    $display("overload test done");
    for (int m = 0; m < 4; m++) begin
      pins(m[0], m[1], 32'h0);
      chk(control_mode, mtab[m]);
      chk(p1_oe, m == 0);
    end
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      pins(1'b1, 1'b1, r);
      chk(control_mode, MODE_STATIC);
      chk(ratio, r[3] ? CLK_384 : CLK_256);
      chk(deem, r[5:4] == 2'h1 ? DEEMPH_44K1 : DEEMPH_NONE);
      chk(mute, r[5]);
      chk(fmt, ftab[{r[6], r[0]}]);
      chk(pdn, r[2:1] == 2'h0);
      chk(gain, r[2:1] == 2'h1);
      chk(p1_oe, 1'b0);
    end
    $display("mode and static pin test done");
    results();
  end
endmodule : codec_control_mode_interface_tb
